// [verilog/adcd_pkg.sv]
/*
 Package for the converter diagnostic, modulator delay and chop configuration registers.
 Holds the register offsets, field positions, reset values and code tables.
 Assumes an 8-bit register port with 8-bit register offsets.
*/
`default_nettype none

package adcd_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADDR_DIAG_RECEIVE_SELECT = 8'h56;
   localparam logic [7:0] ADDR_DIAG_LEVEL_MUX_CONTROL = 8'h57;
   localparam logic [7:0] ADDR_MODULATOR_CLOCK_DELAY = 8'h58;
   localparam logic [7:0] ADDR_GROUP_CHOP_RATE = 8'h59;

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_DIAG_RECEIVE_SELECT = 8'h00;
   localparam logic [7:0] RST_DIAG_LEVEL_MUX_CONTROL = 8'h00;
   localparam logic [7:0] RST_MODULATOR_CLOCK_DELAY = 8'h02;
   localparam logic [7:0] RST_GROUP_CHOP_RATE = 8'h0A;

   // ==========================================================
   // Field positions
   localparam int GROUP_A_DIAG_LSB = 0;
   localparam int GROUP_B_DIAG_LSB = 4;
   localparam int DELAYED_MODCLK_LSB = 2;
   localparam int DELAY_RESERVED_LSB = 0;
   localparam int GROUP_A_CHOP_LSB = 2;
   localparam int GROUP_B_CHOP_LSB = 0;

   // Writable bits per register; the rest read as zero
   localparam logic [7:0] MASK_DIAG_LEVEL_MUX_CONTROL = 8'h77;
   localparam logic [7:0] MASK_MODULATOR_CLOCK_DELAY = 8'h0F;
   localparam logic [7:0] MASK_GROUP_CHOP_RATE = 8'h0F;

   // ==========================================================
   // Codes
   localparam logic [2:0] DIAG_CODE_OFF = 3'h0;
   localparam logic [2:0] DIAG_CODE_POS = 3'h3;
   localparam logic [2:0] DIAG_CODE_NEG = 3'h4;
   localparam logic [2:0] DIAG_CODE_ZERO = 3'h5;

   localparam logic [1:0] DELAY_CODE_NONE = 2'h0;
   localparam logic [1:0] DELAY_CODE_LOW = 2'h1;
   localparam logic [1:0] DELAY_CODE_HIGH = 2'h2;
   localparam logic [1:0] DELAY_CODE_ALL = 2'h3;

   localparam logic [1:0] CHOP_CODE_DIV8 = 2'h1;
   localparam logic [1:0] CHOP_CODE_DIV32 = 2'h2;

   // Level applied to one channel's converter input
   typedef enum logic [1:0] {
      ADCD_LEVEL_OFF = 2'b00,
      ADCD_LEVEL_POS = 2'b01,
      ADCD_LEVEL_NEG = 2'b10,
      ADCD_LEVEL_ZERO = 2'b11
   } adcd_level_t;

   // Effective chop rate of a group
   typedef enum logic {
      ADCD_CHOP_DIV8 = 1'b0,
      ADCD_CHOP_DIV32 = 1'b1
   } adcd_chop_t;

endpackage

`default_nettype wire

// [verilog/adcd_cfg_if.sv]
/*
 Interface between the register bank and its routing and chop helpers.
 Assumes all parties share one clock; results are combinational.
*/
`timescale 1ns/1ps
`default_nettype none

interface adcd_cfg_if #(parameter int NUM_CHAN = 8);
   logic [NUM_CHAN-1:0] receive;
   logic [NUM_CHAN-1:0] chan_group_b;
   logic [2:0] group_a_diag_level;
   logic [2:0] group_b_diag_level;
   logic [1:0] group_a_chop_rate;
   logic [1:0] group_b_chop_rate;
   adcd_pkg::adcd_level_t chan_level [NUM_CHAN];
   adcd_pkg::adcd_chop_t chop_a;
   adcd_pkg::adcd_chop_t chop_b;

   modport regs (
      output receive, chan_group_b, group_a_diag_level, group_b_diag_level,
      output group_a_chop_rate, group_b_chop_rate,
      input chan_level, chop_a, chop_b
   );
   modport route (
      input receive, chan_group_b, group_a_diag_level, group_b_diag_level,
      output chan_level
   );
   modport chop (
      input group_a_chop_rate, group_b_chop_rate,
      output chop_a, chop_b
   );
endinterface

`default_nettype wire

// [verilog/adcd_diag_route.sv]
/*
 Routes the group diagnostic levels to each channel.
 Assumes the group assignment comes from the channel mode select register.
*/
`timescale 1ns/1ps
`default_nettype none

module adcd_diag_route #(
   parameter int NUM_CHAN = 8
) (
   // Configuration
   adcd_cfg_if.route cfg
);

   // ==========================================================
   // Decode
   // Reserved codes fall back to off so no stray level is applied
   function automatic adcd_pkg::adcd_level_t decode_level(input logic [2:0] code);
      case (code)
         adcd_pkg::DIAG_CODE_POS: decode_level = adcd_pkg::ADCD_LEVEL_POS;
         adcd_pkg::DIAG_CODE_NEG: decode_level = adcd_pkg::ADCD_LEVEL_NEG;
         adcd_pkg::DIAG_CODE_ZERO: decode_level = adcd_pkg::ADCD_LEVEL_ZERO;
         default: decode_level = adcd_pkg::ADCD_LEVEL_OFF;
      endcase
   endfunction

   // ==========================================================
   // Per-channel routing
   always_comb begin
      for (int n = 0; n < NUM_CHAN; n++) begin
         if (!cfg.receive[n]) begin
            cfg.chan_level[n] = adcd_pkg::ADCD_LEVEL_OFF;
         end else if (cfg.chan_group_b[n]) begin
            cfg.chan_level[n] = decode_level(cfg.group_b_diag_level);
         end else begin
            cfg.chan_level[n] = decode_level(cfg.group_a_diag_level);
         end
      end
   end

endmodule // adcd_diag_route

`default_nettype wire

// [verilog/adcd_chop_hold.sv]
/*
 Keeps the effective chop rate of each group.
 Assumes the register field may hold a reserved code; then the last good rate stays.
*/
`timescale 1ns/1ps
`default_nettype none

module adcd_chop_hold (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Configuration
   adcd_cfg_if.chop cfg
);

   adcd_pkg::adcd_chop_t rate_a;
   adcd_pkg::adcd_chop_t rate_b;
   adcd_pkg::adcd_chop_t next_rate_a;
   adcd_pkg::adcd_chop_t next_rate_b;

   // ==========================================================
   // Decode with hold
   function automatic adcd_pkg::adcd_chop_t chop_next(input logic [1:0] code,
                                                      input adcd_pkg::adcd_chop_t prev);
      case (code)
         adcd_pkg::CHOP_CODE_DIV8: chop_next = adcd_pkg::ADCD_CHOP_DIV8;
         adcd_pkg::CHOP_CODE_DIV32: chop_next = adcd_pkg::ADCD_CHOP_DIV32;
         default: chop_next = prev;
      endcase
   endfunction

   always_comb begin
      next_rate_a = chop_next(cfg.group_a_chop_rate, rate_a);
      next_rate_b = chop_next(cfg.group_b_chop_rate, rate_b);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rate_a <= adcd_pkg::ADCD_CHOP_DIV32;
         rate_b <= adcd_pkg::ADCD_CHOP_DIV32;
      end else begin
         rate_a <= next_rate_a;
         rate_b <= next_rate_b;
      end
   end

   // Combinational view so the top can register the fresh rate
   assign cfg.chop_a = next_rate_a;
   assign cfg.chop_b = next_rate_b;

   // ==========================================================
   // Checks
   chop_hold_a: assert property (@(posedge clk) disable iff (reset)
      (cfg.group_a_chop_rate inside {2'h0, 2'h3}) |=> $stable(rate_a))
      else $error("group A chop rate changed on a reserved code");
   chop_decode_a: assert property (@(posedge clk) disable iff (reset)
      cfg.group_b_chop_rate == adcd_pkg::CHOP_CODE_DIV8 |=> rate_b == adcd_pkg::ADCD_CHOP_DIV8)
      else $error("group B chop rate not one eighth after code 01");

endmodule // adcd_chop_hold

`default_nettype wire

// [verilog/adcd_regs.sv]
/*
 Register bank for the converter's diagnostic receive and level mux, delayed
 modulator clock and group chop rate, with registered per-channel controls.
 Assumes a plain register port (address, write data, strobes, read data one
 cycle later) and that the channel group assignment is driven from outside.
*/
// Notes on behaviour
// - Receive bit n enables diagnostics for channel n
// - Mux bits 2:0 group A, 6:4 group B
// - Codes 011 positive, 100 negative, 101 zero
// - Channel follows its group's select
// - Delay field 3:2 picks delayed channel halves
// - Chop A bits 3:2, B 1:0; 01=/8, 10=/32
// - Chop register resets to 0x0A
// - Mux and receive registers reset to zero
// - Delay register resets to 0x02
`timescale 1ns/1ps
`default_nettype none

module adcd_regs #(
   parameter int NUM_CHAN = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // Channel group assignment, 1 = group B
   input wire logic [NUM_CHAN-1:0] chan_group_b,
   // Per-channel diagnostic control
   output logic [NUM_CHAN-1:0] chan_diag_receive,
   output logic [2*NUM_CHAN-1:0] chan_diag_level,
   // Modulator clock and chop control
   output logic [NUM_CHAN-1:0] delayed_modclk_enable,
   output logic group_a_chop_div32,
   output logic group_b_chop_div32
);

   // ==========================================================
   // Parameter check
   // The delay field splits channels into two fixed halves of four
   if (NUM_CHAN != 8) begin : g_bad_num_chan
      $error("adcd_regs supports exactly eight channels");
   end

   localparam int HALF = NUM_CHAN / 2;

   // ==========================================================
   // Register state
   logic [7:0] diag_receive_select;
   logic [7:0] diag_level_mux_control;
   logic [7:0] modulator_clock_delay;
   logic [7:0] group_chop_rate;
   logic [7:0] next_diag_receive_select;
   logic [7:0] next_diag_level_mux_control;
   logic [7:0] next_modulator_clock_delay;
   logic [7:0] next_group_chop_rate;
   logic [7:0] next_rdata;

   // Registered outputs
   logic [NUM_CHAN-1:0] next_chan_diag_receive;
   logic [2*NUM_CHAN-1:0] next_chan_diag_level;
   logic [NUM_CHAN-1:0] next_delayed_modclk_enable;
   logic next_group_a_chop_div32;
   logic next_group_b_chop_div32;

   adcd_cfg_if #(.NUM_CHAN(NUM_CHAN)) cfg ();

   // ==========================================================
   // Helpers
   adcd_diag_route #(.NUM_CHAN(NUM_CHAN)) u_route (
      .cfg (cfg.route)
   );

   adcd_chop_hold u_chop (
      .clk (clk),
      .reset (reset),
      .cfg (cfg.chop)
   );

   // Writes keep only the bits the register implements
   function automatic logic [7:0] write_masked(input logic [7:0] data,
                                               input logic [7:0] mask);
      write_masked = data & mask;
   endfunction

   // ==========================================================
   // Register writes
   always_comb begin
      next_diag_receive_select = diag_receive_select;
      next_diag_level_mux_control = diag_level_mux_control;
      next_modulator_clock_delay = modulator_clock_delay;
      next_group_chop_rate = group_chop_rate;
      if (wr) begin
         case (addr)
            adcd_pkg::ADDR_DIAG_RECEIVE_SELECT: begin
               next_diag_receive_select = wdata;
            end
            adcd_pkg::ADDR_DIAG_LEVEL_MUX_CONTROL: begin
               next_diag_level_mux_control =
                  write_masked(wdata, adcd_pkg::MASK_DIAG_LEVEL_MUX_CONTROL);
            end
            adcd_pkg::ADDR_MODULATOR_CLOCK_DELAY: begin
               // Reserved low bits stored as written so readback shows them
               next_modulator_clock_delay =
                  write_masked(wdata, adcd_pkg::MASK_MODULATOR_CLOCK_DELAY);
            end
            adcd_pkg::ADDR_GROUP_CHOP_RATE: begin
               next_group_chop_rate =
                  write_masked(wdata, adcd_pkg::MASK_GROUP_CHOP_RATE);
            end
            default: begin
               next_group_chop_rate = group_chop_rate;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         diag_receive_select <= adcd_pkg::RST_DIAG_RECEIVE_SELECT;
         diag_level_mux_control <= adcd_pkg::RST_DIAG_LEVEL_MUX_CONTROL;
         modulator_clock_delay <= adcd_pkg::RST_MODULATOR_CLOCK_DELAY;
         group_chop_rate <= adcd_pkg::RST_GROUP_CHOP_RATE;
      end else begin
         diag_receive_select <= next_diag_receive_select;
         diag_level_mux_control <= next_diag_level_mux_control;
         modulator_clock_delay <= next_modulator_clock_delay;
         group_chop_rate <= next_group_chop_rate;
      end
   end

   // ==========================================================
   // Register reads
   // Read data stands only in the cycle after the strobe
   always_comb begin
      next_rdata = 8'h00;
      if (rd) begin
         case (addr)
            adcd_pkg::ADDR_DIAG_RECEIVE_SELECT: next_rdata = diag_receive_select;
            adcd_pkg::ADDR_DIAG_LEVEL_MUX_CONTROL: next_rdata = diag_level_mux_control;
            adcd_pkg::ADDR_MODULATOR_CLOCK_DELAY: next_rdata = modulator_clock_delay;
            adcd_pkg::ADDR_GROUP_CHOP_RATE: next_rdata = group_chop_rate;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Fields to helpers
   assign cfg.receive = diag_receive_select[NUM_CHAN-1:0];
   assign cfg.chan_group_b = chan_group_b;
   assign cfg.group_a_diag_level =
      diag_level_mux_control[adcd_pkg::GROUP_A_DIAG_LSB +: 3];
   assign cfg.group_b_diag_level =
      diag_level_mux_control[adcd_pkg::GROUP_B_DIAG_LSB +: 3];
   assign cfg.group_a_chop_rate = group_chop_rate[adcd_pkg::GROUP_A_CHOP_LSB +: 2];
   assign cfg.group_b_chop_rate = group_chop_rate[adcd_pkg::GROUP_B_CHOP_LSB +: 2];

   // ==========================================================
   // Channel controls
   always_comb begin
      next_chan_diag_receive = diag_receive_select[NUM_CHAN-1:0];
      for (int n = 0; n < NUM_CHAN; n++) begin
         next_chan_diag_level[2*n +: 2] = cfg.chan_level[n];
      end
      case (modulator_clock_delay[adcd_pkg::DELAYED_MODCLK_LSB +: 2])
         adcd_pkg::DELAY_CODE_NONE: next_delayed_modclk_enable = '0;
         adcd_pkg::DELAY_CODE_LOW: next_delayed_modclk_enable = {{HALF{1'b0}}, {HALF{1'b1}}};
         adcd_pkg::DELAY_CODE_HIGH: next_delayed_modclk_enable = {{HALF{1'b1}}, {HALF{1'b0}}};
         adcd_pkg::DELAY_CODE_ALL: next_delayed_modclk_enable = '1;
         default: next_delayed_modclk_enable = '0;
      endcase
      next_group_a_chop_div32 = (cfg.chop_a == adcd_pkg::ADCD_CHOP_DIV32);
      next_group_b_chop_div32 = (cfg.chop_b == adcd_pkg::ADCD_CHOP_DIV32);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata <= 8'h00;
         chan_diag_receive <= '0;
         chan_diag_level <= '0;
         delayed_modclk_enable <= '0;
         group_a_chop_div32 <= 1'b1;
         group_b_chop_div32 <= 1'b1;
      end else begin
         rdata <= next_rdata;
         chan_diag_receive <= next_chan_diag_receive;
         chan_diag_level <= next_chan_diag_level;
         delayed_modclk_enable <= next_delayed_modclk_enable;
         group_a_chop_div32 <= next_group_a_chop_div32;
         group_b_chop_div32 <= next_group_b_chop_div32;
      end
   end

   // ==========================================================
   // Checks
   sequence reg_write(logic [7:0] a);
      wr && addr == a;
   endsequence

   sequence reg_read(logic [7:0] a);
      rd && !wr && addr == a;
   endsequence

   reset_values_a: assert property (@(posedge clk)
      reset |=> diag_receive_select == 8'h00 && diag_level_mux_control == 8'h00)
      else $error("receive or mux register not zero after reset");
   chop_reset_a: assert property (@(posedge clk)
      reset ##1 !reset |-> group_chop_rate == 8'h0A)
      else $error("chop register not 0x0A after reset");
   delay_reset_a: assert property (@(posedge clk)
      reset |=> modulator_clock_delay == 8'h02 && delayed_modclk_enable == 8'h00)
      else $error("delay register not 0x02 after reset");
   receive_write_a: assert property (@(posedge clk) disable iff (reset)
      reg_write(8'h56) ##1 (!wr)[*1] ##0 reg_read(8'h56)
      |=> rdata == $past(wdata, 2))
      else $error("receive register readback differs from written value");
   upper_zero_a: assert property (@(posedge clk) disable iff (reset)
      (reg_read(8'h59) or reg_read(8'h58)) |=> rdata[7:4] == 4'h0)
      else $error("unused upper bits did not read as zero");
   mux_gap_a: assert property (@(posedge clk) disable iff (reset)
      reg_read(8'h57) |=> rdata[3] == 1'b0 && rdata[7] == 1'b0)
      else $error("mux register spare bits did not read as zero");
   group_a_pos_a: assert property (@(posedge clk) disable iff (reset)
      diag_receive_select[0] && !chan_group_b[0] && diag_level_mux_control[2:0] == 3'h3
      |=> chan_diag_level[1:0] == 2'b01)
      else $error("channel 0 not at positive level for group A code 011");
   group_b_zero_a: assert property (@(posedge clk) disable iff (reset)
      diag_receive_select[7] && chan_group_b[7] && diag_level_mux_control[6:4] == 3'h5
      |=> chan_diag_level[15:14] == 2'b11)
      else $error("channel 7 not at zero level for group B code 101");
   reserved_off_a: assert property (@(posedge clk) disable iff (reset)
      diag_level_mux_control[2:0] inside {3'h1, 3'h2, 3'h6, 3'h7} && !chan_group_b[1]
      |=> chan_diag_level[3:2] == 2'b00)
      else $error("reserved diagnostic code did not leave channel 1 off");
   unused_off_a: assert property (@(posedge clk) disable iff (reset)
      !diag_receive_select[2] |=> chan_diag_level[5:4] == 2'b00)
      else $error("channel 2 got a level while not receiving");
   delay_low_a: assert property (@(posedge clk) disable iff (reset)
      modulator_clock_delay[3:2] == 2'b01 |=> delayed_modclk_enable == 8'h0F)
      else $error("delay code 01 did not select channels 0 to 3");
   delay_high_a: assert property (@(posedge clk) disable iff (reset)
      modulator_clock_delay[3:2] == 2'b10 |=> delayed_modclk_enable == 8'hF0)
      else $error("delay code 10 did not select channels 4 to 7");
   chop_rate_a: assert property (@(posedge clk) disable iff (reset)
      group_chop_rate[3:2] == 2'b01 |=> !group_a_chop_div32)
      else $error("group A chop rate not one eighth after code 01");

endmodule // adcd_regs

`default_nettype wire

// [verilog/adcd_unused_placeholder_none.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [sim/tb_adc_diag_chop_config_regs.sv]
/*
 Self-checking bench for the diagnostic, modulator delay and chop register bank.
 Assumes the bank answers reads one cycle late and drives its channel outputs
 one cycle after a register or group assignment changes.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_adc_diag_chop_config_regs;
   // ==========================================================
   // Signals
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] chan_group_b = 8'h00;
   logic [7:0] rdata;
   logic [7:0] chan_diag_receive;
   logic [15:0] chan_diag_level;
   logic [7:0] delayed_modclk_enable;
   logic group_a_chop_div32;
   logic group_b_chop_div32;
   integer seed = 32'hc35b;
   int mismatches = 0;
   int checks_done = 0;
   logic [7:0] rx, mux, d;
   logic a32, b32;

   always #2 clk = ~clk;

   adcd_regs #(.NUM_CHAN(8)) DUT (
      .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .chan_group_b(chan_group_b), .chan_diag_receive(chan_diag_receive),
      .chan_diag_level(chan_diag_level), .delayed_modclk_enable(delayed_modclk_enable),
      .group_a_chop_div32(group_a_chop_div32), .group_b_chop_div32(group_b_chop_div32)
   );

   // ==========================================================
   // Expectations
   function automatic logic [15:0] exp_level(logic [7:0] r, logic [7:0] g, logic [7:0] m);
      logic [15:0] v;
      logic [2:0] c;
      v = 16'h0000;
      for (int n = 0; n < 8; n++) begin
         c = g[n] ? m[6:4] : m[2:0];
         if (r[n]) begin
            case (c)
               3'h3: v[2*n +: 2] = 2'h1;
               3'h4: v[2*n +: 2] = 2'h2;
               3'h5: v[2*n +: 2] = 2'h3;
               default: v[2*n +: 2] = 2'h0;
            endcase
         end
      end
      return v;
   endfunction

   function automatic logic [7:0] exp_delay(logic [1:0] c);
      return {{4{c[1]}}, {4{c[0]}}};
   endfunction

   // ==========================================================
   // Tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk({8'h00, rdata}, {8'h00, exp});
      // Read data must not linger past its one cycle
      @(posedge clk);
      #1;
      chk({8'h00, rdata}, 16'h0000);
   endtask

   // Outputs are registered one cycle behind the bank
   task automatic settle();
      @(posedge clk);
      #1;
   endtask

   task automatic check_reset_state();
      settle();
      chk({8'h00, chan_diag_receive}, 16'h0000);
      chk(chan_diag_level, 16'h0000);
      chk({8'h00, delayed_modclk_enable}, 16'h0000);
      chk({14'h0000, group_a_chop_div32, group_b_chop_div32}, 16'h0003);
      rd_chk(adcd_pkg::ADDR_DIAG_RECEIVE_SELECT, 8'h00);
      rd_chk(adcd_pkg::ADDR_DIAG_LEVEL_MUX_CONTROL, 8'h00);
      rd_chk(adcd_pkg::ADDR_MODULATOR_CLOCK_DELAY, 8'h02);
      rd_chk(adcd_pkg::ADDR_GROUP_CHOP_RATE, 8'h0A);
   endtask

   task automatic final_report();
      $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Watchdog, far beyond the roughly 400 cycles the sequence needs
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      final_report();
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      check_reset_state();
      // Unmapped places neither store nor answer
      wr_reg(8'h5A, 8'hFF);
      rd_chk(8'h5A, 8'h00);
      rd_chk(8'h55, 8'h00);
      // Every group code on both fields, random group split; receivers all on for the first eight passes, then random
      for (int i = 0; i < 16; i++) begin
         rx = (i < 8) ? 8'hFF : 8'($random(seed));
         mux = 8'($random(seed));
         mux[2:0] = 3'(i);
         mux[6:4] = 3'(7 - i);
         // Precharge buffers of receiving channels are on outside this bank
         wr_reg(adcd_pkg::ADDR_DIAG_RECEIVE_SELECT, rx);
         chan_group_b <= 8'($random(seed));
         wr_reg(adcd_pkg::ADDR_DIAG_LEVEL_MUX_CONTROL, mux);
         settle();
         chk({8'h00, chan_diag_receive}, {8'h00, rx});
         chk(chan_diag_level, exp_level(rx, chan_group_b, mux));
         rd_chk(adcd_pkg::ADDR_DIAG_LEVEL_MUX_CONTROL, mux & 8'h77);
         rd_chk(adcd_pkg::ADDR_DIAG_RECEIVE_SELECT, rx);
      end
      // Group split alone flipped; last codes 111 and 000 both decode to off, so levels stay zero
      @(posedge clk);
      chan_group_b <= ~chan_group_b;
      settle();
      settle();
      chk(chan_diag_level, exp_level(rx, chan_group_b, mux));
      // Delay halves, reserved pair always written as 2
      for (int c = 0; c < 4; c++) begin
         d = {4'($random(seed)), 2'(c), 2'h2};
         wr_reg(adcd_pkg::ADDR_MODULATOR_CLOCK_DELAY, d);
         settle();
         chk({8'h00, delayed_modclk_enable}, {8'h00, exp_delay(2'(c))});
         rd_chk(adcd_pkg::ADDR_MODULATOR_CLOCK_DELAY, d & 8'h0F);
      end
      // Chop codes, reserved ones keep the last good rate
      a32 = 1'b1;
      b32 = 1'b1;
      for (int i = 0; i < 24; i++) begin
         d = (i < 16) ? 8'(i * 8'h11) : 8'($random(seed));
         if (d[3:2] == 2'h1) a32 = 1'b0;
         if (d[3:2] == 2'h2) a32 = 1'b1;
         if (d[1:0] == 2'h1) b32 = 1'b0;
         if (d[1:0] == 2'h2) b32 = 1'b1;
         wr_reg(adcd_pkg::ADDR_GROUP_CHOP_RATE, d);
         settle();
         chk({14'h0000, group_a_chop_div32, group_b_chop_div32}, {14'h0000, a32, b32});
         rd_chk(adcd_pkg::ADDR_GROUP_CHOP_RATE, d & 8'h0F);
      end
      // Write then read back with no gap between the strobes
      @(posedge clk);
      addr <= adcd_pkg::ADDR_DIAG_RECEIVE_SELECT;
      wdata <= 8'h3C;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk({8'h00, rdata}, 16'h003C);
      // Second reset in mid-run restores every register
      wr_reg(adcd_pkg::ADDR_DIAG_RECEIVE_SELECT, 8'hA5);
      wr_reg(adcd_pkg::ADDR_DIAG_LEVEL_MUX_CONTROL, 8'h53);
      @(posedge clk);
      reset <= 1'b1;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      check_reset_state();
      final_report();
   end
endmodule // tb_adc_diag_chop_config_regs

`default_nettype wire
